// >>> design/sscr_pkg.sv
// Package with the register map, field masks and timing constants of the supply status bank
package sscr_pkg;

   // Printed register numbers are word indices; the byte address is four times the index
   localparam logic [15:0] IDX_FAULT_STATUS_WORD = 16'h9cc1;
   localparam logic [15:0] IDX_WARNING_STATUS_WORD = 16'h9cc3;
   localparam logic [15:0] IDX_FACTORY_FAULT_WORD = 16'h9cc5;
   localparam logic [15:0] IDX_EXT_MODEL_IDENTIFIER = 16'h9cc9;
   localparam logic [15:0] IDX_EXT_MODEL_LENGTH = 16'h9cca;
   localparam logic [15:0] IDX_CONTROL_ORIGIN_SELECT = 16'h9ccb;
   localparam logic [15:0] IDX_SUPPLY_HEARTBEAT = 16'h9ccc;
   localparam logic [15:0] IDX_HOST_HEARTBEAT = 16'h9ccd;
   localparam logic [15:0] IDX_FAULT_CLEAR_COMMAND = 16'h9cce;
   localparam logic [15:0] IDX_OPERATION_COMMAND = 16'h9ccf;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 17;

   // Implemented bits of the three status words; all others are reserved and read zero
   localparam logic [31:0] FAULT_VALID_MASK = 32'h1bfc0fff;
   localparam logic [31:0] WARNING_VALID_MASK = 32'h47ffb0ff;
   localparam logic [31:0] FACTORY_VALID_MASK = 32'h00fbffff;

   localparam int FAULT_BIT_COMM_ERROR = 21;
   localparam int FAULT_BIT_ANY_FACTORY = 25;

   localparam logic [15:0] EXT_MODEL_LENGTH_VALUE = 16'h0008;
   // Arbitrary neutral identifier, not a real model number
   localparam logic [15:0] EXT_MODEL_ID_DEFAULT = 16'h1234;

   localparam logic [15:0] FAULT_CLEAR_NONE = 16'h0000;
   localparam logic [15:0] FAULT_CLEAR_DO = 16'h0001;

   typedef enum logic [2:0] {
      SSCR_OP_NONE = 3'h0,
      SSCR_OP_CONNECT = 3'h1,
      SSCR_OP_DISCONNECT = 3'h2,
      SSCR_OP_STANDBY = 3'h3,
      SSCR_OP_RUN = 3'h4
   } sscr_op_e;
   localparam logic [15:0] OP_CMD_MAX = 16'h0004;

   // Time base
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned HEARTBEAT_PERIOD_S = 1;
   localparam int unsigned HOST_TIMEOUT_S = 3;
   localparam int unsigned CYCLES_PER_BEAT = CLK_HZ * HEARTBEAT_PERIOD_S;
   localparam int unsigned CYCLES_HOST_TIMEOUT = CLK_HZ * HOST_TIMEOUT_S;

endpackage : sscr_pkg

// >>> design/sscr_regs.sv
// APB register bank for supply fault, warning and factory status plus host control words
//
// Summary of operation
// - Fault bits 0-11: overcurrent and overvoltage flags
// - Fault bits 18-25: lock, temp, halt, config
// - Fault bit 27 retries, bit 28 timeout
// - Warning bits 0-7: high current and voltage
// - Warning 12-13 limiting, 15 lock lost
// - Warning 16-18 temperatures, 19-21 fan errors
// - Warning 22-26 tolerance, retry; 30 suppressor
// - Factory bits 0-5: switch overcurrent bottom/top
// - Factory 6-8 overcurrent, 9-11 imbalance
// - Factory 12-17: link voltage, precharge, bias
// - Factory 19-23 comms, log, config, calibration
// - Extension header: identifier, length of eight
// - Supply heartbeat counts seconds from zero
// - Stale host heartbeat raises a fault
// - Timeout armed only after first write
// - Operation command: connect, disconnect, standby, run
// - Command registers self clear; 1 clears faults
`timescale 1ns/1ps
`default_nettype none

module sscr_regs #(
   parameter int unsigned BEAT_CYCLES = sscr_pkg::CYCLES_PER_BEAT,
   parameter int unsigned HOST_TIMEOUT_CYCLES = sscr_pkg::CYCLES_HOST_TIMEOUT,
   parameter logic [15:0] MODEL_ID = sscr_pkg::EXT_MODEL_ID_DEFAULT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sscr_pkg::ADDR_W-1:0] paddr,
   input wire logic [sscr_pkg::DATA_W-1:0] pwdata,
   output logic [sscr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] fault_flags,
   input wire logic [31:0] warning_flags,
   input wire logic [31:0] factory_flags,
   input wire logic local_operator_panel,
   output logic [2:0] op_command,
   output logic op_command_strobe,
   output logic fault_clear_strobe,
   output logic host_heartbeat_fault
);

   typedef struct packed {
      logic [2:0][31:0] fault_sync;
      logic [2:0][31:0] warn_sync;
      logic [2:0][31:0] fact_sync;
      logic [2:0] panel_sync;
      logic [31:0] fault_filt;
      logic [31:0] warn_filt;
      logic [31:0] fact_filt;
      logic panel_filt;
      logic [31:0] fault_word;
      logic [31:0] fact_word;
      logic [31:0] sec_cnt;
      logic [15:0] supply_beat;
      logic [15:0] host_beat;
      logic armed;
      logic [31:0] idle_cnt;
      logic hb_fault;
      logic [31:0] rdata;
      logic [2:0] op_cmd;
      logic op_stb;
      logic clr_stb;
   } sscr_state_s;

   sscr_state_s st;
   sscr_state_s next_st;

   logic [15:0] idx;
   logic aligned;
   logic hit_any;
   logic ro_hit;
   logic setup;
   logic wr_done;
   logic wr_bad;
   logic [15:0] wlo;
   logic [31:0] fault_view;
   logic [31:0] warn_view;
   logic [31:0] fact_view;

   assign idx = paddr[sscr_pkg::IDX_MSB:sscr_pkg::IDX_LSB];
   assign aligned = (paddr[sscr_pkg::IDX_LSB-1:0] == '0)
                    && (paddr[sscr_pkg::ADDR_W-1:sscr_pkg::IDX_MSB+1] == '0);
   assign wlo = pwdata[15:0];
   assign setup = psel && !penable;

   always_comb begin
      ro_hit = 1'b0;
      hit_any = 1'b1;
      unique case (idx)
         sscr_pkg::IDX_FAULT_STATUS_WORD,
         sscr_pkg::IDX_WARNING_STATUS_WORD,
         sscr_pkg::IDX_FACTORY_FAULT_WORD,
         sscr_pkg::IDX_EXT_MODEL_IDENTIFIER,
         sscr_pkg::IDX_EXT_MODEL_LENGTH,
         sscr_pkg::IDX_CONTROL_ORIGIN_SELECT,
         sscr_pkg::IDX_SUPPLY_HEARTBEAT: ro_hit = 1'b1;
         sscr_pkg::IDX_HOST_HEARTBEAT,
         sscr_pkg::IDX_FAULT_CLEAR_COMMAND,
         sscr_pkg::IDX_OPERATION_COMMAND: ro_hit = 1'b0;
         default: hit_any = 1'b0;
      endcase
      hit_any = hit_any && aligned;
   end

   // Writes with a value outside the legal range are refused and leave no effect
   always_comb begin
      wr_bad = 1'b0;
      if (!hit_any || ro_hit) begin
         wr_bad = 1'b1;
      end else if (idx == sscr_pkg::IDX_FAULT_CLEAR_COMMAND) begin
         wr_bad = (pwdata > {16'h0000, sscr_pkg::FAULT_CLEAR_DO});
      end else if (idx == sscr_pkg::IDX_OPERATION_COMMAND) begin
         wr_bad = (pwdata > {16'h0000, sscr_pkg::OP_CMD_MAX});
      end else begin
         wr_bad = (pwdata[31:16] != 16'h0000);
      end
   end

   assign pready = psel && penable;
   assign pslverr = pready && (pwrite ? wr_bad : !hit_any);
   assign wr_done = pready && pwrite && !wr_bad;

   // Reserved positions are masked off on every view, whatever the pins carry
   assign fault_view = st.fault_word & sscr_pkg::FAULT_VALID_MASK;
   assign warn_view = st.warn_filt & sscr_pkg::WARNING_VALID_MASK;
   assign fact_view = st.fact_word & sscr_pkg::FACTORY_VALID_MASK;

   always_comb begin
      logic [31:0] fault_set;
      logic clear_now;
      logic changed;
      fault_set = '0;
      clear_now = 1'b0;
      changed = 1'b0;
      next_st = st;

      // Three-stage input capture; a bit moves only when stages two and three agree
      next_st.fault_sync = {st.fault_sync[1:0], fault_flags};
      next_st.warn_sync = {st.warn_sync[1:0], warning_flags};
      next_st.fact_sync = {st.fact_sync[1:0], factory_flags};
      next_st.panel_sync = {st.panel_sync[1:0], local_operator_panel};
      for (int i = 0; i < 32; i++) begin
         if (st.fault_sync[1][i] == st.fault_sync[2][i]) begin
            next_st.fault_filt[i] = st.fault_sync[2][i];
         end
         if (st.warn_sync[1][i] == st.warn_sync[2][i]) begin
            next_st.warn_filt[i] = st.warn_sync[2][i];
         end
         if (st.fact_sync[1][i] == st.fact_sync[2][i]) begin
            next_st.fact_filt[i] = st.fact_sync[2][i];
         end
      end
      if (st.panel_sync[1] == st.panel_sync[2]) begin
         next_st.panel_filt = st.panel_sync[2];
      end

      next_st.op_stb = 1'b0;
      next_st.clr_stb = 1'b0;
      if (wr_done && idx == sscr_pkg::IDX_FAULT_CLEAR_COMMAND
          && wlo == sscr_pkg::FAULT_CLEAR_DO) begin
         clear_now = 1'b1;
         next_st.clr_stb = 1'b1;
      end
      if (wr_done && idx == sscr_pkg::IDX_OPERATION_COMMAND
          && wlo != 16'h0000) begin
         next_st.op_cmd = wlo[2:0];
         next_st.op_stb = 1'b1;
      end

      // Factory faults latch until a fault reset; a new event beats the clear
      next_st.fact_word = (clear_now ? 32'h0000_0000 : st.fact_word)
                          | (st.fact_filt & sscr_pkg::FACTORY_VALID_MASK);

      // Supply heartbeat: one step per second, wraps through zero at the top
      if (st.sec_cnt >= BEAT_CYCLES - 1) begin
         next_st.sec_cnt = '0;
         next_st.supply_beat = st.supply_beat + 16'h0001;
      end else begin
         next_st.sec_cnt = st.sec_cnt + 32'h0000_0001;
      end

      // Host heartbeat watchdog
      if (wr_done && idx == sscr_pkg::IDX_HOST_HEARTBEAT) begin
         next_st.host_beat = wlo;
         next_st.armed = 1'b1;
         changed = (wlo != st.host_beat) || !st.armed;
      end
      if (changed) begin
         next_st.idle_cnt = '0;
      end else if (st.armed && st.idle_cnt < HOST_TIMEOUT_CYCLES) begin
         next_st.idle_cnt = st.idle_cnt + 32'h0000_0001;
      end
      // The level persists until the host resumes and then clears faults
      if (st.armed && !changed && st.idle_cnt >= HOST_TIMEOUT_CYCLES - 1) begin
         next_st.hb_fault = 1'b1;
      end else if (clear_now && changed) begin
         next_st.hb_fault = 1'b0;
      end else if (clear_now && st.idle_cnt < HOST_TIMEOUT_CYCLES - 1) begin
         next_st.hb_fault = 1'b0;
      end

      // Summary bits follow the next factory word and watchdog level, so a fault reset
      // that also ends their cause does not latch them again from stale state
      fault_set = st.fault_filt & sscr_pkg::FAULT_VALID_MASK;
      fault_set[sscr_pkg::FAULT_BIT_ANY_FACTORY] =
         st.fault_filt[sscr_pkg::FAULT_BIT_ANY_FACTORY] || (|next_st.fact_word);
      fault_set[sscr_pkg::FAULT_BIT_COMM_ERROR] =
         st.fault_filt[sscr_pkg::FAULT_BIT_COMM_ERROR] || next_st.hb_fault;
      next_st.fault_word = (clear_now ? 32'h0000_0000 : st.fault_word) | fault_set;

      // Read data is captured in the setup cycle so that it leaves a flop
      if (setup && !pwrite) begin
         next_st.rdata = '0;
         if (aligned) begin
            unique case (idx)
               sscr_pkg::IDX_FAULT_STATUS_WORD: next_st.rdata = fault_view;
               sscr_pkg::IDX_WARNING_STATUS_WORD: next_st.rdata = warn_view;
               sscr_pkg::IDX_FACTORY_FAULT_WORD: next_st.rdata = fact_view;
               sscr_pkg::IDX_EXT_MODEL_IDENTIFIER: next_st.rdata = {16'h0000, MODEL_ID};
               sscr_pkg::IDX_EXT_MODEL_LENGTH:
                  next_st.rdata = {16'h0000, sscr_pkg::EXT_MODEL_LENGTH_VALUE};
               sscr_pkg::IDX_CONTROL_ORIGIN_SELECT: next_st.rdata = {31'h0, st.panel_filt};
               sscr_pkg::IDX_SUPPLY_HEARTBEAT: next_st.rdata = {16'h0000, st.supply_beat};
               sscr_pkg::IDX_HOST_HEARTBEAT: next_st.rdata = {16'h0000, st.host_beat};
               // Command registers self clear, so a read always returns zero
               sscr_pkg::IDX_FAULT_CLEAR_COMMAND: next_st.rdata = '0;
               sscr_pkg::IDX_OPERATION_COMMAND: next_st.rdata = '0;
               default: next_st.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign op_command = st.op_cmd;
   assign op_command_strobe = st.op_stb;
   assign fault_clear_strobe = st.clr_stb;
   assign host_heartbeat_fault = st.hb_fault;

endmodule : sscr_regs

`default_nettype wire

// >>> verif/sscr_regs_monitor.sv
// Checker of the supply status register bank ports
`timescale 1ns/1ps
`default_nettype none
module sscr_regs_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] op_command,
   input wire logic op_command_strobe,
   input wire logic fault_clear_strobe,
   input wire logic host_heartbeat_fault
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic armed;
   wire logic acc = psel && penable;
   sequence s_wr(a);
      acc && pwrite && paddr == a;
   endsequence
   sequence s_rd(a);
      acc && !pwrite && paddr == a;
   endsequence
   wire logic s_wr_now = acc && pwrite && paddr == 32'h27334 && !pslverr;
   // Refused writes must not arm the watchdog either
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) armed <= 1'b0;
      else if (s_wr_now) armed <= 1'b1;
   end
   a_op_strobe_value: assert property (s_wr(32'h2733c) ##0 pwdata inside {[1:4]}
      |=> op_command_strobe && op_command == $past(pwdata[2:0])) else $error("op not taken");
   a_op_range_refused: assert property (s_wr(32'h2733c) ##0 pwdata > 32'h4
      |-> pslverr ##1 !op_command_strobe && $stable(op_command)) else $error("op over range");
   a_op_strobe_cause: assert property ($rose(op_command_strobe)
      |-> $past(acc && pwrite && paddr == 32'h2733c)) else $error("stray op strobe");
   a_clear_on_one: assert property (s_wr(32'h27338) ##0 pwdata == 32'h1
      |=> fault_clear_strobe) else $error("fault clear missed");
   a_clear_cause: assert property (fault_clear_strobe
      |-> $past(acc && pwrite && pwdata == 32'h1)) else $error("stray fault clear");
   a_cmd_read_zero: assert property ((s_rd(32'h27338) or s_rd(32'h2733c))
      |-> prdata == 32'h0) else $error("command reg not cleared");
   a_strobe_single: assert property (op_command_strobe |=> !op_command_strobe)
      else $error("op strobe too long");
   a_length_eight: assert property (s_rd(32'h27328) |-> prdata == 32'h8 && !pslverr)
      else $error("model length wrong");
   a_status_ro: assert property ((s_wr(32'h27304) or s_wr(32'h2730c)
      or s_wr(32'h27314)) |-> pslverr) else $error("status write accepted");
   a_fault_reserved: assert property (s_rd(32'h27304)
      |-> (prdata & ~sscr_pkg::FAULT_VALID_MASK) == 32'h0) else $error("reserved bit set");
   a_hb_unarmed: assert property (!armed |-> !host_heartbeat_fault)
      else $error("watchdog fired unarmed");
   a_hb_range: assert property (s_wr(32'h27334) ##0 pwdata > 32'hffff |-> pslverr)
      else $error("heartbeat over range");
endmodule : sscr_regs_monitor
bind sscr_regs sscr_regs_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .op_command(op_command),
   .op_command_strobe(op_command_strobe), .fault_clear_strobe(fault_clear_strobe),
   .host_heartbeat_fault(host_heartbeat_fault));
`default_nettype wire

// >>> verif/sscr_host_model.sv
// Host controller model: APB master that polls, commands and beats its heartbeat
`timescale 1ns/1ps
`default_nettype none
module sscr_host_model (
   input wire logic pclk,
   output var logic psel,
   output var logic penable,
   output var logic pwrite,
   output var logic [31:0] paddr,
   output var logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [15:0] hb_count = 16'h0;
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No wait limit here; a hung slave is caught by the bench timeout
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show a changed pattern, not the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   task automatic beat();
      logic [31:0] r;
      logic e;
      hb_count++;
      xfer(1'b1, 32'h27334, {16'h0, hb_count}, r, e);
   endtask : beat
endmodule : sscr_host_model
`default_nettype wire

// >>> verif/sscr_regs_test.sv
// Testbench of the supply status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin bad_count++; \
   $display("mismatch %s exp %h got %h", n, x, g); end end
module sscr_regs_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, panel, opstb, clrstb, hbf, e;
   logic [31:0] paddr, pwdata, prdata, fault_f, warn_f, fact_f, r;
   logic [2:0] op, last;
   logic [31:0] msk [3] = '{sscr_pkg::FAULT_VALID_MASK, sscr_pkg::WARNING_VALID_MASK,
      sscr_pkg::FACTORY_VALID_MASK};
   int bad_count = 0, total_checks = 0, cycles = 0;
   sscr_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Short beat and timeout keep the run brief; model id value is arbitrary
   sscr_regs #(.BEAT_CYCLES(20), .HOST_TIMEOUT_CYCLES(50), .MODEL_ID(16'h0abc)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_flags(fault_f), .warning_flags(warn_f), .factory_flags(fact_f),
      .local_operator_panel(panel), .op_command(op), .op_command_strobe(opstb),
      .fault_clear_strobe(clrstb), .host_heartbeat_fault(hbf));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task rd(input logic [31:0] a);
      u_host.xfer(1'b0, a, 32'h0, r, e);
   endtask : rd
   task wr(input logic [31:0] a, d);
      u_host.xfer(1'b1, a, d, r, e);
   endtask : wr
   initial begin
      {presetn, panel, fault_f, warn_f, fact_f} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(32'h27328); `CHK("length", 32'h8, r)
      rd(32'h27324); `CHK("model id", 32'h0abc, r)
      rd(32'h27330); `CHK("beat start", 32'h0, r)
      repeat (97) @(posedge pclk);
      rd(32'h27330); `CHK("beat count", 32'h5, r)
      panel <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(32'h2732c); `CHK("origin", 32'h1, r)
      {fault_f, warn_f, fact_f} <= '1;
      repeat (6) @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         rd(32'h27304 + 8 * i); `CHK("status", msk[i], r)
      end
      wr(32'h27304, 32'h0); `CHK("ro refused", 1'b1, e)
      {fault_f, warn_f, fact_f} <= '0;
      repeat (6) @(posedge pclk);
      rd(32'h2730c); `CHK("warning live", 32'h0, r)
      rd(32'h27304); `CHK("fault sticky", msk[0], r)
      wr(32'h27338, 32'h1);
      @(negedge pclk); `CHK("clear strobe", 1'b1, clrstb)
      rd(32'h27304); `CHK("fault cleared", 32'h0, r)
      rd(32'h27314); `CHK("factory cleared", 32'h0, r)
      last = 3'h0;
      for (int v = 0; v < 6; v++) begin
         wr(32'h2733c, 32'(v)); `CHK("op refused", v > 4, e)
         if (v inside {[1:4]}) last = 3'(v);
         @(negedge pclk); `CHK("op command", last, op)
         `CHK("op strobe", v inside {[1:4]}, opstb)
      end
      rd(32'h2733c); `CHK("op self clear", 32'h0, r)
      `CHK("unarmed", 1'b0, hbf)
      wr(32'h27334, 32'h10000); `CHK("hb range", 1'b1, e)
      repeat (4) begin
         u_host.beat();
         repeat (30) @(posedge pclk);
      end
      `CHK("hb alive", 1'b0, hbf)
      rd(32'h27334); `CHK("hb value", 32'h4, r)
      repeat (4) begin
         wr(32'h27334, 32'h4);
         repeat (20) @(posedge pclk);
      end
      `CHK("hb stale", 1'b1, hbf)
      rd(32'h27304); `CHK("comm fault", 1'b1, r[21])
      u_host.beat();
      wr(32'h27338, 32'h1);
      repeat (2) @(negedge pclk); `CHK("hb recovered", 1'b0, hbf)
      rd(32'h27304); `CHK("comm fault cleared", 1'b0, r[21])
      rd(32'h27300); `CHK("unmapped", {1'b1, 32'h0}, {e, r})
      summarize();
   end
endmodule : sscr_regs_test
`default_nettype wire
